/* design/ccf_top.sv */
// file: control and status register bank of one voltage comparator
`timescale 1ns/1ns
`default_nettype none
//Operation
// - bit 7 enables the comparator
// - bit 6 reads live comparison result
// - bit 5 sets on rising output edge
// - bit 4 sets on falling output edge
// - bits 3-2 select positive hysteresis
// - bits 1-0 select negative hysteresis
// - event flags sticky until software clears
// - disabled: pin output low, events suspended
module ccf_top
    import ccf_pkg::*;
(
    input wire logic CLK_SYS,
    input wire logic RESET,
    input wire logic SFR_WR,
    input wire logic SFR_RD,
    input wire logic [7:0] SFR_ADDR,
    input wire logic [7:0] SFR_WDATA,
    input wire logic CMP_RAW,
    output logic [7:0] SFR_RDATA,
    output logic CMP_EN,
    output logic [1:0] CMP_POS_HYS,
    output logic [1:0] CMP_NEG_HYS,
    output logic CMP_PIN_OUT,
    output logic RISE_EVENT_FLAG,
    output logic FALL_EVENT_FLAG
);
    ccf_bus_req_t req; // bundled bus request
    ccf_analog_cfg_t cfg_ff; // settings held for the analog core
    ccf_analog_cfg_t nxt_cfg;
    logic rise_ff; // sticky rising flag
    logic nxt_rise;
    logic fall_ff; // sticky falling flag
    logic nxt_fall;
    logic result_ff; // synchronised result seen by software
    logic nxt_result;
    logic pin_ff; // gated pin output
    logic nxt_pin;
    logic [7:0] rdata_ff; // read data register
    logic [7:0] nxt_rdata;
    logic level; // synchronised comparator output
    logic rise; // one-cycle rising edge
    logic fall; // one-cycle falling edge
    logic hit_wr; // write to our register
    logic hit_rd; // read of our register

    assign req = '{wr: SFR_WR, rd: SFR_RD, addr: SFR_ADDR, wdata: SFR_WDATA};
    assign hit_wr = req.wr && (req.addr == CCF_CTRL_ADDR);
    assign hit_rd = req.rd && (req.addr == CCF_CTRL_ADDR);

    // raw analog output is asynchronous to the system clock
    ccf_sync_edge #(
        .STAGES(CCF_SYNC_STAGES)
    ) u_sync (
        .clk(CLK_SYS),
        .rst(RESET),
        .async_in(CMP_RAW),
        .level(level),
        .rise(rise),
        .fall(fall)
    );

    // build the image of the control register as software sees it
    function automatic logic [7:0] ccf_image(input ccf_analog_cfg_t c, input logic res,
                                              input logic rf, input logic ff);
        logic [7:0] v;
        v = CCF_CTRL_RESET;
        v[CCF_BIT_ENABLE] = c.enable;
        v[CCF_BIT_RESULT] = res;
        v[CCF_BIT_RISE] = rf;
        v[CCF_BIT_FALL] = ff;
        v[CCF_POS_HYS_HI:CCF_POS_HYS_LO] = c.pos_hys;
        v[CCF_NEG_HYS_HI:CCF_NEG_HYS_LO] = c.neg_hys;
        return v;
    endfunction : ccf_image

    // next state of settings, flags and outputs
    always_comb begin
        nxt_cfg = cfg_ff;
        nxt_rise = rise_ff;
        nxt_fall = fall_ff;
        if (hit_wr) begin
            // writable fields take the written value
            nxt_cfg.enable = req.wdata[CCF_BIT_ENABLE];
            nxt_cfg.pos_hys = req.wdata[CCF_POS_HYS_HI:CCF_POS_HYS_LO];
            nxt_cfg.neg_hys = req.wdata[CCF_NEG_HYS_HI:CCF_NEG_HYS_LO];
            // only a zero clears; writing one leaves the flag alone
            if (!req.wdata[CCF_BIT_RISE]) begin
                nxt_rise = 1'b0;
            end
            if (!req.wdata[CCF_BIT_FALL]) begin
                nxt_fall = 1'b0;
            end
        end
        // hardware set wins over a same-cycle clear; gated while off
        if (cfg_ff.enable && rise) begin
            nxt_rise = 1'b1;
        end
        if (cfg_ff.enable && fall) begin
            nxt_fall = 1'b1;
        end
        // result tracks the live comparator
        nxt_result = level;
        // pin held low while disabled
        nxt_pin = cfg_ff.enable & level;
        // read data reflects state at the moment of the read
        nxt_rdata = hit_rd ? ccf_image(cfg_ff, result_ff, rise_ff, fall_ff) : 8'h00;
    end

    // register everything; all clears to zero
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            cfg_ff <= '0;
            rise_ff <= 1'b0;
            fall_ff <= 1'b0;
            result_ff <= 1'b0;
            pin_ff <= 1'b0;
            rdata_ff <= CCF_CTRL_RESET;
        end else begin
            cfg_ff <= nxt_cfg;
            rise_ff <= nxt_rise;
            fall_ff <= nxt_fall;
            result_ff <= nxt_result;
            pin_ff <= nxt_pin;
            rdata_ff <= nxt_rdata;
        end
    end

    // outputs straight from flip-flops
    assign SFR_RDATA = rdata_ff;
    assign CMP_EN = cfg_ff.enable;
    assign CMP_POS_HYS = cfg_ff.pos_hys;
    assign CMP_NEG_HYS = cfg_ff.neg_hys;
    assign CMP_PIN_OUT = pin_ff;
    assign RISE_EVENT_FLAG = rise_ff;
    assign FALL_EVENT_FLAG = fall_ff;

    // enable write reaches the core next cycle
    property p_enable_write;
        @(posedge CLK_SYS) disable iff (RESET)
        hit_wr |=> (CMP_EN == $past(req.wdata[CCF_BIT_ENABLE]));
    endproperty
    a_enable_write: assert property (p_enable_write) else $error("enable not written");

    // result bit follows synchronised level one cycle later
    property p_result;
        @(posedge CLK_SYS) disable iff (RESET)
        1'b1 |=> (result_ff == $past(level));
    endproperty
    a_result: assert property (p_result) else $error("result stale");

    // enabled rising edge sets the flag
    property p_rise_set;
        @(posedge CLK_SYS) disable iff (RESET)
        (rise && cfg_ff.enable) |=> RISE_EVENT_FLAG;
    endproperty
    a_rise_set: assert property (p_rise_set) else $error("rise flag not set");

    // enabled falling edge sets the flag
    property p_fall_set;
        @(posedge CLK_SYS) disable iff (RESET)
        (fall && cfg_ff.enable) |=> FALL_EVENT_FLAG;
    endproperty
    a_fall_set: assert property (p_fall_set) else $error("fall flag not set");

    // positive hysteresis follows write
    property p_pos_hys;
        @(posedge CLK_SYS) disable iff (RESET)
        hit_wr |=> (CMP_POS_HYS == $past(req.wdata[CCF_POS_HYS_HI:CCF_POS_HYS_LO]));
    endproperty
    a_pos_hys: assert property (p_pos_hys) else $error("positive hysteresis wrong");

    // negative hysteresis holds without a write
    property p_neg_hys;
        @(posedge CLK_SYS) disable iff (RESET)
        !hit_wr |=> $stable(CMP_NEG_HYS);
    endproperty
    a_neg_hys: assert property (p_neg_hys) else $error("negative hysteresis moved");

    // flag stays set without a clearing write
    property p_sticky;
        @(posedge CLK_SYS) disable iff (RESET)
        (RISE_EVENT_FLAG && !(hit_wr && !req.wdata[CCF_BIT_RISE])) |=> RISE_EVENT_FLAG;
    endproperty
    a_sticky: assert property (p_sticky) else $error("rise flag dropped");

    // pin low and no new flags while disabled
    property p_disabled;
        @(posedge CLK_SYS) disable iff (RESET)
        (!CMP_EN && !hit_wr && !RISE_EVENT_FLAG && !FALL_EVENT_FLAG)
            |=> (!RISE_EVENT_FLAG && !FALL_EVENT_FLAG && !CMP_PIN_OUT);
    endproperty
    a_disabled: assert property (p_disabled) else $error("disabled comparator active");

    // clear by zero write, unless an edge lands together
    property p_clear;
        @(posedge CLK_SYS) disable iff (RESET)
        (hit_wr && !req.wdata[CCF_BIT_FALL] && !(fall && cfg_ff.enable)) |=> !FALL_EVENT_FLAG;
    endproperty
    a_clear: assert property (p_clear) else $error("fall flag not cleared");
endmodule : ccf_top
`default_nettype wire

/* design/ccf_pkg.sv */
// package: register offset, field positions and carrier types for the comparator control flags
package ccf_pkg;
    // special-function register offset of the control register
    localparam logic [7:0] CCF_CTRL_ADDR = 8'h9E;
    // reset value of the whole register
    localparam logic [7:0] CCF_CTRL_RESET = 8'h00;
    // field positions
    localparam int CCF_BIT_ENABLE = 7;
    localparam int CCF_BIT_RESULT = 6;
    localparam int CCF_BIT_RISE = 5;
    localparam int CCF_BIT_FALL = 4;
    localparam int CCF_POS_HYS_HI = 3;
    localparam int CCF_POS_HYS_LO = 2;
    localparam int CCF_NEG_HYS_HI = 1;
    localparam int CCF_NEG_HYS_LO = 0;
    // hysteresis code that switches negative hysteresis off
    localparam logic [1:0] CCF_NEG_HYS_OFF = 2'h0;
    // synchroniser stages
    localparam int CCF_SYNC_STAGES = 2;

    // special-function bus request
    typedef struct packed {
        logic wr;         // write strobe
        logic rd;         // read strobe
        logic [7:0] addr; // register address
        logic [7:0] wdata; // write data
    } ccf_bus_req_t;

    // settings forwarded to the analog core
    typedef struct packed {
        logic enable;
        logic [1:0] pos_hys;
        logic [1:0] neg_hys;
    } ccf_analog_cfg_t;
endpackage : ccf_pkg

/* design/ccf_sync_edge.sv */
// file: synchroniser and edge detector for the raw comparator output
`timescale 1ns/1ns
`default_nettype none
module ccf_sync_edge
    import ccf_pkg::*;
#(
    parameter int STAGES = CCF_SYNC_STAGES
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic async_in,
    output logic level,
    output logic rise,
    output logic fall
);
    logic [STAGES-1:0] sync_ff; // sync chain, bit 0 is the first stage
    logic [STAGES-1:0] nxt_sync;
    logic prev_ff; // last synchronised sample
    logic nxt_prev;

    // shift the chain; only the last stage is looked at
    always_comb begin
        nxt_sync = {sync_ff[STAGES-2:0], async_in};
        nxt_prev = sync_ff[STAGES-1];
    end

    // register the chain, clear on reset
    always_ff @(posedge clk) begin
        if (rst) begin
            sync_ff <= '0;
            prev_ff <= 1'b0;
        end else begin
            sync_ff <= nxt_sync;
            prev_ff <= nxt_prev;
        end
    end

    // edges from successive synchronised samples
    assign level = sync_ff[STAGES-1];
    assign rise = level & ~prev_ff;
    assign fall = ~level & prev_ff;
endmodule : ccf_sync_edge
`default_nettype wire

/* tb/ccf_analog_model.sv */
// behavioural model of the analog comparator core facing the register bank
`timescale 1ns/1ns
`default_nettype none
module ccf_analog_model
    import ccf_pkg::*;
(
    input wire ccf_analog_cfg_t cfg,
    input wire logic above,
    output logic raw
);
    // hysteresis is not modelled: the bench only sets clean, well-separated levels
    // raw is high while the non-inverting input is above the inverting input
    assign raw = above;
endmodule : ccf_analog_model
`default_nettype wire

/* tb/testbench.sv */
// self-checking bench for the comparator control register bank
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import ccf_pkg::*;
    logic clk_sys = 1'b0; // system clock, 50 ns
    logic reset = 1'b1; // held for 5 cycles
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic above = 1'b0; // commanded input relation
    logic raw;
    logic [7:0] rdata;
    logic en, pin, rise_f, fall_f;
    logic [1:0] pos, neg;
    wire [7:0] outs = {en, pin, rise_f, fall_f, pos, neg}; // outputs in image order
    int err_total = 0;
    int check_count = 0;

    always #25 clk_sys = ~clk_sys;

    ccf_analog_model core (.cfg({en, pos, neg}), .above(above), .raw(raw));

    ccf_top uut (.CLK_SYS(clk_sys), .RESET(reset), .SFR_WR(wr), .SFR_RD(rd),
        .SFR_ADDR(addr), .SFR_WDATA(wdata), .CMP_RAW(raw), .SFR_RDATA(rdata),
        .CMP_EN(en), .CMP_POS_HYS(pos), .CMP_NEG_HYS(neg), .CMP_PIN_OUT(pin),
        .RISE_EVENT_FLAG(rise_f), .FALL_EVENT_FLAG(fall_f));

    // compare and count
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // one write strobe, then an idle cycle so the strobe never re-rises in one step
    task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge clk_sys);
        wr = 1'b0;
        @(negedge clk_sys);
    endtask : sfr_wr

    // read strobe; data stands only in the cycle after the taking edge
    task automatic sfr_rd(input logic [7:0] a, input logic [7:0] exp);
        addr = a;
        rd = 1'b1;
        @(negedge clk_sys);
        rd = 1'b0;
        chk("read data", exp, rdata);
        @(negedge clk_sys);
    endtask : sfr_rd

    task automatic settle();
        repeat (4) @(negedge clk_sys);
    endtask : settle

    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : close_out

    // watchdog: the sequence needs well under 300 cycles
    initial begin
        #100000;
        err_total++;
        close_out();
    end

    initial begin
        repeat (5) @(negedge clk_sys);
        reset = 1'b0;
        @(negedge clk_sys);
        chk("outputs after reset", CCF_CTRL_RESET, outs);
        sfr_rd(CCF_CTRL_ADDR, CCF_CTRL_RESET);
        sfr_wr(CCF_CTRL_ADDR, 8'h8C);
        chk("config outputs", 8'h8C, outs);
        sfr_rd(CCF_CTRL_ADDR, 8'h8C);
        // ones into the read-only and flag bits must not stick
        sfr_wr(CCF_CTRL_ADDR, 8'hFF);
        sfr_rd(CCF_CTRL_ADDR, 8'h8F);
        // every hysteresis code pair reaches the core
        for (int i = 0; i < 16; i++) begin
            sfr_wr(CCF_CTRL_ADDR, {4'h8, i[3:0]});
            chk("hysteresis codes", {4'h8, i[3:0]}, outs);
        end
        sfr_wr(CCF_CTRL_ADDR, 8'h80);
        above = 1'b1;
        settle();
        chk("rise outputs", 8'hE0, outs);
        sfr_rd(CCF_CTRL_ADDR, 8'hE0);
        above = 1'b0;
        settle();
        chk("fall outputs, rise kept", 8'hB0, outs);
        sfr_rd(CCF_CTRL_ADDR, 8'hB0);
        sfr_wr(CCF_CTRL_ADDR, 8'h80);
        sfr_rd(CCF_CTRL_ADDR, 8'h80);
        // disabled: a rising edge sets nothing and the pin stays low
        sfr_wr(CCF_CTRL_ADDR, 8'h00);
        above = 1'b1;
        settle();
        chk("disabled outputs", 8'h00, outs);
        sfr_rd(CCF_CTRL_ADDR, 8'h40);
        sfr_wr(CCF_CTRL_ADDR, 8'h80);
        sfr_rd(CCF_CTRL_ADDR, 8'hC0);
        // clearing write taken on the very edge that sees the falling pulse
        above = 1'b0;
        repeat (2) @(negedge clk_sys);
        sfr_wr(CCF_CTRL_ADDR, 8'h80);
        chk("set wins over clear", 8'h90, outs);
        sfr_rd(CCF_CTRL_ADDR, 8'h90);
        // unmapped address is ignored and reads zero
        sfr_wr(8'h9F, 8'h00);
        sfr_rd(CCF_CTRL_ADDR, 8'h90);
        sfr_rd(8'h9F, 8'h00);
        close_out();
    end
endmodule : testbench
`default_nettype wire
